//--- design/dcp_cache_ctrl.v
//
// How it works
// - Enabled cache looks up every load, store
// - Copyback store hit: update, set half dirty
// - Writethrough store hit: update, also write buffer
// - Store misses always go to write buffer
// - Store misses never allocate a line
// - Evicted valid dirty halves written back first
// - Cacheable load miss fills eight words, random set
// - Noncacheable load miss reads externally, cache untouched
// - Load hit returns data only if cacheable
// - Cacheable and bufferable means copyback
// - Cacheable, not bufferable means writethrough
// - Multiples split at each 4 KB boundary
// - Flush all invalidates everything, no writeback
// - Flush entry invalidates line, drops dirty data
// - Clean entry writes dirty line, keeps valid
// - Clean-and-flush writes dirty line, then invalidates
// - Operand: set in 31:30, index N:5
// - N is 9 for 4 KB four-way
// - N is log2(size/128) plus 4
// - Lock whole sets from zero, one free
// - Lockdown driven by lock index and load bit
// - Reset disables cache, invalidates all lines
// - Only valid lines can hit
// - Disabled cache forces noncacheable, buffering still decoded only while protEnable is on
`timescale 1ns/10ps
`include "dcp_defs.vh"
module dcp_cache_ctrl (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Control bits
   input wire cacheEnable,
   input wire protEnable,
   input wire [1:0] lockSetIdx,
   input wire lockLoad,
   // Region attributes of the current access
   input wire cacheableDataAttr,
   input wire bufferableDataAttr,
   // Core request
   input wire reqValid,
   input wire reqWrite,
   input wire reqMulti,
   input wire [31:0] reqAddr,
   input wire [31:0] reqWdata,
   // Core answer
   output reg reqDone_ff,
   output reg rspValid_ff,
   output reg [31:0] rspData_ff,
   output reg partSplit_ff,
   // Maintenance
   input wire maintValid,
   input wire [1:0] maintOp,
   input wire maintByAddr,
   input wire [31:0] maintOperand,
   output reg maintDone_ff,
   // Write buffer
   output reg wbValid_ff,
   output reg [31:0] wbAddr_ff,
   output reg [31:0] wbData_ff,
   output reg wbBuffered_ff,
   input wire wbReady,
   // External reads
   output reg memReqValid_ff,
   output reg [31:0] memReqAddr_ff,
   output reg memReqLine_ff,
   input wire memRdValid,
   input wire [31:0] memRdData
);

   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_SPLIT = 6'h02;
   localparam [5:0] S_STWB = 6'h04;
   localparam [5:0] S_EVICT = 6'h08;
   localparam [5:0] S_FILL = 6'h10;
   localparam [5:0] S_NCRD = 6'h20;

   reg [5:0] state_ff;
   reg [`DCP_SLOTS-1:0] valid_ff;
   reg [`DCP_SLOTS-1:0] dirtyLo_ff;
   reg [`DCP_SLOTS-1:0] dirtyHi_ff;
   reg [`DCP_TAG_W-1:0] tagRam_ff [0:`DCP_SLOTS-1];
   reg [31:0] dataRam_ff [0:`DCP_WORDS-1];
   reg [`DCP_SLOT_W-1:0] vSlot_ff;
   reg [2:0] cnt_ff;
   reg maintMode_ff;
   reg flushAfter_ff;
   reg [26:0] fillLine_ff;
   reg [`DCP_PAGE_W-1:0] lastPage_ff;

   wire [1:0] victimWay;
   wire [31:0] lkAddr;
   wire [4:0] lkIdx;
   wire [`DCP_TAG_W-1:0] lkTag;
   wire [3:0] hitWay;
   wire [1:0] hitEnc;
   wire anyHit;
   wire cacheOn;
   wire effCacheable;
   wire reqHit;
   wire [`DCP_SLOT_W-1:0] hSlot;
   wire [`DCP_SLOT_W-1:0] mSlot;
   wire mFound;
   wire vDirty;
   wire [`DCP_SLOT_W-1:0] victimSlot;
   wire [2:0] nextWord;

   dcp_victim_sel uVictim (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .lockSetIdx(lockSetIdx),
      .lockLoad(lockLoad),
      .victimWay_ff(victimWay)
   );

   // Maintenance by address shares the tag compare with the core
   assign lkAddr = maintValid ? maintOperand : reqAddr;
   assign lkIdx = lkAddr[`DCP_IDX_HI:`DCP_IDX_LO];
   assign lkTag = lkAddr[31:`DCP_TAG_LO];

   genvar g;
   generate
      for (g = 0; g < `DCP_WAYS; g = g + 1)
      begin : gWay
         assign hitWay[g] = valid_ff[g * 32 + lkIdx] &&
                            (tagRam_ff[g * 32 + lkIdx] == lkTag);
      end
   endgenerate

   assign anyHit = |hitWay;
   assign hitEnc = hitWay[3] ? 2'h3 : hitWay[2] ? 2'h2 : hitWay[1] ? 2'h1 : 2'h0;
   assign hSlot = {hitEnc, lkIdx};

   // Cache works only with the protection unit on
   assign cacheOn = cacheEnable & protEnable;
   assign effCacheable = cacheOn & cacheableDataAttr;
   assign reqHit = effCacheable & anyHit;

   // Set/index operands take the set from the top two bits
   assign mSlot = maintByAddr ? hSlot :
                  {maintOperand[`DCP_SET_HI:`DCP_SET_LO], lkIdx};
   assign mFound = maintByAddr ? anyHit : valid_ff[mSlot];

   assign victimSlot = {victimWay, lkIdx};
   assign vDirty = valid_ff[victimSlot] &
                   (dirtyLo_ff[victimSlot] | dirtyHi_ff[victimSlot]);

   // Word that follows the current one during a writeback
   assign nextWord = (cnt_ff == `DCP_LAST_LO) ? `DCP_FIRST_HI : cnt_ff + 3'h1;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= S_IDLE;
         valid_ff <= {`DCP_SLOTS{1'b0}};
         dirtyLo_ff <= {`DCP_SLOTS{1'b0}};
         dirtyHi_ff <= {`DCP_SLOTS{1'b0}};
         vSlot_ff <= 7'h00;
         cnt_ff <= 3'h0;
         maintMode_ff <= 1'b0;
         flushAfter_ff <= 1'b0;
         fillLine_ff <= 27'h0000000;
         lastPage_ff <= 20'h00000;
         reqDone_ff <= 1'b0;
         rspValid_ff <= 1'b0;
         rspData_ff <= 32'h00000000;
         partSplit_ff <= 1'b0;
         maintDone_ff <= 1'b0;
         wbValid_ff <= 1'b0;
         wbAddr_ff <= 32'h00000000;
         wbData_ff <= 32'h00000000;
         wbBuffered_ff <= 1'b0;
         memReqValid_ff <= 1'b0;
         memReqAddr_ff <= 32'h00000000;
         memReqLine_ff <= 1'b0;
      end
      else
      begin
         reqDone_ff <= 1'b0;
         rspValid_ff <= 1'b0;
         partSplit_ff <= 1'b0;
         maintDone_ff <= 1'b0;
         memReqValid_ff <= 1'b0;
         case (state_ff)
            S_IDLE:
            begin
               // Maintenance takes priority over the core
               if (maintValid)
               begin
                  if (maintOp == `DCP_OP_FLUSH_ALL)
                  begin
                     valid_ff <= {`DCP_SLOTS{1'b0}};
                     dirtyLo_ff <= {`DCP_SLOTS{1'b0}};
                     dirtyHi_ff <= {`DCP_SLOTS{1'b0}};
                     maintDone_ff <= 1'b1;
                  end
                  else if (!mFound)
                     maintDone_ff <= 1'b1;
                  else if (maintOp == `DCP_OP_FLUSH_ENTRY)
                  begin
                     valid_ff[mSlot] <= 1'b0;
                     dirtyLo_ff[mSlot] <= 1'b0;
                     dirtyHi_ff[mSlot] <= 1'b0;
                     maintDone_ff <= 1'b1;
                  end
                  else if (dirtyLo_ff[mSlot] | dirtyHi_ff[mSlot])
                  begin
                     vSlot_ff <= mSlot;
                     maintMode_ff <= 1'b1;
                     flushAfter_ff <= (maintOp == `DCP_OP_CLEAN_FLUSH);
                     cnt_ff <= dirtyLo_ff[mSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI;
                     wbValid_ff <= 1'b1;
                     wbBuffered_ff <= 1'b1;
                     wbAddr_ff <= {tagRam_ff[mSlot], mSlot[4:0],
                                   dirtyLo_ff[mSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI, 2'h0};
                     wbData_ff <= dataRam_ff[{mSlot,
                                  dirtyLo_ff[mSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI}];
                     state_ff <= S_EVICT;
                  end
                  else
                  begin
                     // Clean line: nothing to write back
                     if (maintOp == `DCP_OP_CLEAN_FLUSH)
                        valid_ff[mSlot] <= 1'b0;
                     maintDone_ff <= 1'b1;
                  end
               end
               else if (reqValid)
               begin
                  if (reqMulti && (reqAddr[31:`DCP_PAGE_LO] != lastPage_ff))
                  begin
                     // Held one cycle so fresh attributes apply to the new part
                     partSplit_ff <= 1'b1;
                     lastPage_ff <= reqAddr[31:`DCP_PAGE_LO];
                     state_ff <= S_SPLIT;
                  end
                  else if (reqWrite)
                  begin
                     lastPage_ff <= reqAddr[31:`DCP_PAGE_LO];
                     if (reqHit)
                        dataRam_ff[{hSlot, reqAddr[`DCP_WORD_HI:`DCP_WORD_LO]}] <= reqWdata;
                     if (reqHit && bufferableDataAttr)
                     begin
                        if (reqAddr[`DCP_HALF_BIT])
                           dirtyHi_ff[hSlot] <= 1'b1;
                        else
                           dirtyLo_ff[hSlot] <= 1'b1;
                        reqDone_ff <= 1'b1;
                     end
                     else
                     begin
                        // Misses never allocate
                        wbValid_ff <= 1'b1;
                        wbAddr_ff <= reqAddr;
                        wbData_ff <= reqWdata;
                        wbBuffered_ff <= protEnable & bufferableDataAttr;
                        state_ff <= S_STWB;
                     end
                  end
                  else if (reqHit)
                  begin
                     lastPage_ff <= reqAddr[31:`DCP_PAGE_LO];
                     rspData_ff <= dataRam_ff[{hSlot,
                                   reqAddr[`DCP_WORD_HI:`DCP_WORD_LO]}];
                     rspValid_ff <= 1'b1;
                     reqDone_ff <= 1'b1;
                  end
                  else if (effCacheable)
                  begin
                     // Request stays pending; it hits once the fill lands
                     vSlot_ff <= victimSlot;
                     maintMode_ff <= 1'b0;
                     flushAfter_ff <= 1'b0;
                     fillLine_ff <= reqAddr[31:`DCP_IDX_LO];
                     if (vDirty)
                     begin
                        cnt_ff <= dirtyLo_ff[victimSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI;
                        wbValid_ff <= 1'b1;
                        wbBuffered_ff <= 1'b1;
                        wbAddr_ff <= {tagRam_ff[victimSlot], lkIdx,
                           dirtyLo_ff[victimSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI, 2'h0};
                        wbData_ff <= dataRam_ff[{victimSlot,
                           dirtyLo_ff[victimSlot] ? `DCP_FIRST_LO : `DCP_FIRST_HI}];
                        state_ff <= S_EVICT;
                     end
                     else
                     begin
                        valid_ff[victimSlot] <= 1'b0;
                        cnt_ff <= 3'h0;
                        memReqValid_ff <= 1'b1;
                        memReqAddr_ff <= {reqAddr[31:`DCP_IDX_LO], 5'h00};
                        memReqLine_ff <= 1'b1;
                        state_ff <= S_FILL;
                     end
                  end
                  else
                  begin
                     lastPage_ff <= reqAddr[31:`DCP_PAGE_LO];
                     memReqValid_ff <= 1'b1;
                     memReqAddr_ff <= reqAddr;
                     memReqLine_ff <= 1'b0;
                     state_ff <= S_NCRD;
                  end
               end
            end
            S_SPLIT:
               state_ff <= S_IDLE;
            S_STWB:
               if (wbReady)
               begin
                  wbValid_ff <= 1'b0;
                  reqDone_ff <= 1'b1;
                  state_ff <= S_IDLE;
               end
            S_EVICT:
               if (wbReady)
               begin
                  if ((cnt_ff == `DCP_LAST_WORD) ||
                      ((cnt_ff == `DCP_LAST_LO) && !dirtyHi_ff[vSlot_ff]))
                  begin
                     // Line fully drained; nothing overwrote it before now
                     wbValid_ff <= 1'b0;
                     if (maintMode_ff)
                     begin
                        dirtyLo_ff[vSlot_ff] <= 1'b0;
                        dirtyHi_ff[vSlot_ff] <= 1'b0;
                        if (flushAfter_ff)
                           valid_ff[vSlot_ff] <= 1'b0;
                        maintDone_ff <= 1'b1;
                        state_ff <= S_IDLE;
                     end
                     else
                     begin
                        valid_ff[vSlot_ff] <= 1'b0;
                        cnt_ff <= 3'h0;
                        memReqValid_ff <= 1'b1;
                        memReqAddr_ff <= {fillLine_ff, 5'h00};
                        memReqLine_ff <= 1'b1;
                        state_ff <= S_FILL;
                     end
                  end
                  else
                  begin
                     cnt_ff <= nextWord;
                     wbAddr_ff <= {tagRam_ff[vSlot_ff], vSlot_ff[4:0], nextWord, 2'h0};
                     wbData_ff <= dataRam_ff[{vSlot_ff, nextWord}];
                  end
               end
            S_FILL:
               if (memRdValid)
               begin
                  // Words arrive from word 0 of the aligned line
                  dataRam_ff[{vSlot_ff, cnt_ff}] <= memRdData;
                  cnt_ff <= cnt_ff + 3'h1;
                  if (cnt_ff == `DCP_LAST_WORD)
                  begin
                     tagRam_ff[vSlot_ff] <= fillLine_ff[26:5];
                     valid_ff[vSlot_ff] <= 1'b1;
                     dirtyLo_ff[vSlot_ff] <= 1'b0;
                     dirtyHi_ff[vSlot_ff] <= 1'b0;
                     state_ff <= S_IDLE;
                  end
               end
            S_NCRD:
               if (memRdValid)
               begin
                  rspData_ff <= memRdData;
                  rspValid_ff <= 1'b1;
                  reqDone_ff <= 1'b1;
                  state_ff <= S_IDLE;
               end
            default:
               state_ff <= S_IDLE;
         endcase
      end
   end

endmodule

//--- design/dcp_defs.vh
`ifndef DCP_DEFS_VH
`define DCP_DEFS_VH

// Geometry: 4 KB, four ways, 32-byte lines
`define DCP_WAYS 4
`define DCP_SLOT_W 7
`define DCP_RAM_W 10
`define DCP_SLOTS 128
`define DCP_WORDS 1024

// Address fields
`define DCP_WORD_HI 4
`define DCP_WORD_LO 2
`define DCP_HALF_BIT 4
`define DCP_IDX_LO 5
// Upper index bit: log2(4096 / 128) + 4
`define DCP_IDX_HI 9
`define DCP_TAG_LO 10
`define DCP_TAG_W 22
`define DCP_PAGE_LO 12
`define DCP_PAGE_W 20

// Set/index operand layout
`define DCP_SET_HI 31
`define DCP_SET_LO 30

// Maintenance operation codes
`define DCP_OP_FLUSH_ALL 2'h0
`define DCP_OP_FLUSH_ENTRY 2'h1
`define DCP_OP_CLEAN 2'h2
`define DCP_OP_CLEAN_FLUSH 2'h3

// Word counts within a line
`define DCP_FIRST_LO 3'h0
`define DCP_LAST_LO 3'h3
`define DCP_FIRST_HI 3'h4
`define DCP_LAST_WORD 3'h7

// Replacement generator
`define DCP_LFSR_SEED 8'h5a
`define DCP_LFSR_TAPS 8'hb8

`endif

//--- design/dcp_victim_sel.v
`timescale 1ns/10ps
`include "dcp_defs.vh"
module dcp_victim_sel (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Lockdown control
   input wire [1:0] lockSetIdx,
   input wire lockLoad,
   // Chosen way
   output reg [1:0] victimWay_ff
);

   reg [7:0] lfsr_ff;
   reg [1:0] span;
   reg [1:0] offs;

   // Free running, so the choice depends on traffic timing
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         lfsr_ff <= `DCP_LFSR_SEED;
      else if (lfsr_ff[0])
         lfsr_ff <= (lfsr_ff >> 1) ^ `DCP_LFSR_TAPS;
      else
         lfsr_ff <= lfsr_ff >> 1;
   end

   // Ways below the lock index are never replaced; way 3 always free
   always @*
   begin
      span = 2'h3 - lockSetIdx;
      case (span)
         2'h0: offs = 2'h0;
         2'h1: offs = {1'b0, lfsr_ff[0]};
         2'h2: offs = (lfsr_ff[1:0] == 2'h3) ? 2'h0 : lfsr_ff[1:0];
         default: offs = lfsr_ff[1:0];
      endcase
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         victimWay_ff <= 2'h3;
      else if (lockLoad)
         victimWay_ff <= lockSetIdx;
      else
         victimWay_ff <= lockSetIdx + offs;
   end

endmodule

//--- testbench/dcp_cache_ctrl_properties.sv
`timescale 1ns/10ps
module dcp_ctrl_checker (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Watched inputs
   input wire cacheEnable,
   input wire protEnable,
   input wire cacheableDataAttr,
   input wire bufferableDataAttr,
   input wire reqValid,
   input wire reqWrite,
   input wire reqMulti,
   input wire [1:0] maintOp,
   input wire wbReady,
   // Watched outputs
   input wire reqDone_ff,
   input wire rspValid_ff,
   input wire partSplit_ff,
   input wire maintDone_ff,
   input wire wbValid_ff,
   input wire [31:0] wbAddr_ff,
   input wire [31:0] wbData_ff,
   input wire memReqValid_ff,
   input wire memReqLine_ff
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   wire cacheOn = cacheEnable && protEnable;
   wire wtStore = reqWrite && cacheableDataAttr && !bufferableDataAttr && cacheOn;
   sequence wbWait;
      wbValid_ff && !wbReady;
   endsequence
   sequence splitStall;
      partSplit_ff ##1 !reqDone_ff && !partSplit_ff;
   endsequence
   a_reset_quiet: assert property (
      $rose(rst_n) |-> !reqDone_ff && !wbValid_ff && !memReqValid_ff)
      else $error("Outputs active after reset");
   a_wt_store_buffered: assert property (
      reqDone_ff && reqValid && wtStore |-> $past(wbValid_ff && wbReady))
      else $error("Writethrough store done without buffer write");
   a_store_no_fill: assert property (
      memReqValid_ff && reqValid |-> !reqWrite)
      else $error("External read during a store");
   a_line_needs_cache: assert property (
      memReqValid_ff && memReqLine_ff |-> cacheOn && cacheableDataAttr)
      else $error("Line fill outside a cacheable enabled access");
   a_fill_after_wb: assert property (
      memReqValid_ff |-> !wbValid_ff)
      else $error("Fill requested while writeback pending");
   a_wb_word_held: assert property (
      wbWait |=> wbValid_ff && $stable(wbAddr_ff) && $stable(wbData_ff))
      else $error("Buffer word changed before acceptance");
   a_split_stall: assert property (
      partSplit_ff |-> splitStall)
      else $error("Split not followed by a stall cycle");
   a_split_multi: assert property (
      partSplit_ff |-> $past(reqValid && reqMulti))
      else $error("Split on a non-multiple access");
   a_flush_no_wb: assert property (
      maintDone_ff && !maintOp[1] |-> !wbValid_ff && !$past(wbValid_ff))
      else $error("Flush wrote back data");
   a_load_data_done: assert property (
      rspValid_ff |-> reqDone_ff && !reqWrite)
      else $error("Load data without completion");
endmodule
bind dcp_cache_ctrl dcp_ctrl_checker u_chk (.*);

//--- testbench/dcp_cache_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "dcp_defs.vh"
module dcp_cache_ctrl_tb_top;
   logic core_clk, rst_n, cacheEnable, protEnable, lockLoad, cacheableDataAttr;
   logic bufferableDataAttr, reqValid, reqWrite, reqMulti, maintValid, maintByAddr, slowWb;
   logic memLine;
   logic [1:0] lockSetIdx, maintOp;
   logic [31:0] reqAddr, reqWdata, maintOperand, rd, wbDat;
   logic [31:0] wbLog [0:15];
   wire reqDone_ff, rspValid_ff, partSplit_ff, maintDone_ff, wbValid_ff, wbBuffered_ff;
   wire wbReady, memReqValid_ff, memReqLine_ff, memRdValid;
   wire [31:0] rspData_ff, wbAddr_ff, wbData_ff, memReqAddr_ff, memRdData;
   int n_mismatch, num_checks, nWb, nMem, nSplit;
   localparam logic [31:0] A = 32'h0000_1040;
   localparam logic [31:0] B = 32'h0000_2040;
   localparam logic [31:0] E = 32'h0000_3040;
   localparam logic [31:0] SI = {2'h1, 20'h0, E[9:5], 5'h00};
   dcp_cache_ctrl DUT (.*);
   dcp_mem_model partner (.core_clk(core_clk), .rst_n(rst_n), .slowWb(slowWb),
      .wbValid(wbValid_ff), .wbReady(wbReady), .memReqValid(memReqValid_ff),
      .memReqAddr(memReqAddr_ff), .memReqLine(memReqLine_ff), .memRdValid(memRdValid),
      .memRdData(memRdData));
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Sampled before the edge's own updates land
   always @(posedge core_clk)
   begin
      if (wbValid_ff && wbReady && nWb < 16)
      begin
         wbLog[nWb] = wbAddr_ff;
         wbDat = wbData_ff;
         nWb++;
      end
      if (memReqValid_ff)
      begin
         nMem++;
         memLine = memReqLine_ff;
      end
      if (partSplit_ff)
         nSplit++;
   end
   function logic [31:0] pat(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction
   task tally_and_finish;
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task step;
      @(posedge core_clk);
      #1;
   endtask
   task clr;
      nWb = 0;
      nMem = 0;
      nSplit = 0;
   endtask
   task endt(input string nm);
      $display("Test %s finished", nm);
   endtask
   task hold(input bit mt);
      int i;
      for (i = 0; i < 3000; i++)
      begin
         step();
         if (rspValid_ff === 1'b1)
            rd = rspData_ff;
         if ((mt ? maintDone_ff : reqDone_ff) === 1'b1)
            return;
      end
      $display("ERROR wait expected done seen timeout");
      n_mismatch++;
      tally_and_finish();
   endtask
   task access(input bit w, m, c, b, input logic [31:0] a, d);
      step();
      reqWrite = w;
      reqMulti = m;
      cacheableDataAttr = c;
      bufferableDataAttr = b;
      reqAddr = a;
      reqWdata = d;
      // Stale load data must not satisfy a later data check
      rd = 32'h0;
      reqValid = 1'b1;
      hold(1'b0);
      reqValid = 1'b0;
   endtask
   task maint(input logic [1:0] op, input bit ba, input logic [31:0] opd);
      step();
      maintOp = op;
      maintByAddr = ba;
      maintOperand = opd;
      maintValid = 1'b1;
      hold(1'b1);
      maintValid = 1'b0;
   endtask
   initial
   begin
      {cacheEnable, protEnable, lockLoad, cacheableDataAttr, bufferableDataAttr} = 5'h00;
      {reqValid, reqWrite, reqMulti, maintValid, maintByAddr, slowWb} = 6'h00;
      {lockSetIdx, maintOp, reqAddr, reqWdata, maintOperand} = 100'h0;
      {n_mismatch, num_checks, nWb, nMem, nSplit} = 160'h0;
      rst_n = 1'b0;
      repeat (16) step();
      rst_n = 1'b1;
      chk("idle outs", {reqDone_ff, wbValid_ff, memReqValid_ff, maintDone_ff}, 32'h0);
      protEnable = 1'b1;
      access(0, 0, 1, 1, A, 32'h0);
      chk("reads", nMem, 32'h1);
      chk("line", memLine, 32'h0);
      chk("data", rd, pat(A));
      endt("disabled");
      cacheEnable = 1'b1;
      lockLoad = 1'b1;
      lockSetIdx = 2'h1;
      clr();
      access(0, 0, 1, 1, A, 32'h0);
      chk("line", memLine, 32'h1);
      chk("data", rd, pat(A));
      access(0, 0, 1, 1, A + 32'h14, 32'h0);
      chk("reads", nMem, 32'h1);
      chk("data", rd, pat(A + 32'h14));
      access(0, 0, 0, 1, A + 32'h14, 32'h0);
      chk("reads", nMem, 32'h2);
      chk("line", memLine, 32'h0);
      endt("fill");
      clr();
      access(1, 0, 1, 1, A, 32'h1111_0001);
      chk("writes", nWb, 32'h0);
      access(1, 0, 1, 0, A + 32'h14, 32'h2222_0002);
      chk("writes", nWb, 32'h1);
      chk("wb addr", wbLog[0], A + 32'h14);
      chk("wb data", wbDat, 32'h2222_0002);
      chk("buffered", wbBuffered_ff, 32'h0);
      access(0, 0, 1, 1, A, 32'h0);
      chk("data", rd, 32'h1111_0001);
      access(0, 0, 1, 1, A + 32'h14, 32'h0);
      chk("data", rd, 32'h2222_0002);
      chk("reads", nMem, 32'h0);
      endt("store hits");
      slowWb = 1'b1;
      clr();
      access(1, 0, 1, 1, B + 32'h8, 32'h0);
      chk("writes", nWb, 32'h1);
      access(0, 0, 1, 1, B, 32'h0);
      chk("reads", nMem, 32'h1);
      chk("writes", nWb, 32'h5);
      chk("wb addr", wbLog[1], A);
      chk("data", rd, pat(B));
      slowWb = 1'b0;
      clr();
      access(1, 0, 1, 1, B, 32'h0);
      access(1, 0, 1, 1, B + 32'h1c, 32'h0);
      access(0, 0, 1, 1, E, 32'h0);
      chk("writes", nWb, 32'h8);
      chk("wb addr", wbLog[0], B);
      chk("wb addr", wbLog[4], B + 32'h10);
      chk("reads", nMem, 32'h1);
      chk("buffered", wbBuffered_ff, 32'h1);
      endt("evict");
      clr();
      access(1, 0, 1, 1, E + 32'h10, 32'h3333_0003);
      maint(`DCP_OP_CLEAN, 1'b1, E);
      chk("writes", nWb, 32'h4);
      chk("wb addr", wbLog[0], E + 32'h10);
      maint(`DCP_OP_CLEAN, 1'b1, E);
      chk("writes", nWb, 32'h4);
      access(0, 0, 1, 1, E + 32'h10, 32'h0);
      chk("reads", nMem, 32'h0);
      chk("data", rd, 32'h3333_0003);
      clr();
      access(1, 0, 1, 1, E, 32'h0);
      maint(`DCP_OP_CLEAN_FLUSH, 1'b0, SI);
      chk("writes", nWb, 32'h4);
      chk("wb addr", wbLog[0], E);
      access(0, 0, 1, 1, E, 32'h0);
      chk("reads", nMem, 32'h1);
      clr();
      access(1, 0, 1, 1, E, 32'h0);
      maint(`DCP_OP_FLUSH_ENTRY, 1'b0, SI);
      access(0, 0, 1, 1, E, 32'h0);
      chk("writes", nWb, 32'h0);
      chk("reads", nMem, 32'h1);
      clr();
      access(1, 0, 1, 1, E, 32'h0);
      maint(`DCP_OP_FLUSH_ALL, 1'b0, 32'h0);
      access(0, 0, 1, 1, E, 32'h0);
      chk("writes", nWb, 32'h0);
      chk("reads", nMem, 32'h1);
      endt("maintenance");
      lockLoad = 1'b0;
      lockSetIdx = 2'h3;
      clr();
      access(0, 0, 1, 1, 32'h0000_4060, 32'h0);
      access(1, 0, 1, 1, 32'h0000_4060, 32'h0);
      maint(`DCP_OP_CLEAN, 1'b0, {2'h3, 20'h0, 5'h03, 5'h00});
      chk("writes", nWb, 32'h4);
      endt("lockdown");
      clr();
      access(1, 0, 0, 1, 32'h0000_1ffc, 32'h0);
      access(1, 1, 0, 1, 32'h0000_2000, 32'h0);
      access(1, 1, 0, 1, 32'h0000_2004, 32'h0);
      chk("splits", nSplit, 32'h1);
      chk("writes", nWb, 32'h3);
      chk("buffered", wbBuffered_ff, 32'h1);
      endt("multiple");
      tally_and_finish();
   end
endmodule

//--- testbench/dcp_mem_model.sv
`timescale 1ns/10ps
module dcp_mem_model (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Stall control
   input wire slowWb,
   // Write buffer side
   input wire wbValid,
   output wire wbReady,
   // External read side
   input wire memReqValid,
   input wire [31:0] memReqAddr,
   input wire memReqLine,
   output wire memRdValid,
   output wire [31:0] memRdData
);
   reg [1:0] tick_ff;
   reg [3:0] left_ff;
   reg [31:0] addr_ff;
   reg rdValid_ff;
   reg [31:0] rdData_ff;
   // Slow mode takes one word in four
   assign wbReady = wbValid & (~slowWb | (tick_ff == 2'h3));
   assign memRdValid = rdValid_ff;
   assign memRdData = rdData_ff;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_ff <= 2'h0;
         left_ff <= 4'h0;
         addr_ff <= 32'h0;
         rdValid_ff <= 1'b0;
         rdData_ff <= 32'h0;
      end
      else
      begin
         tick_ff <= tick_ff + 2'h1;
         rdValid_ff <= 1'b0;
         // Idle bus toggles so stale words never pass
         rdData_ff <= ~rdData_ff;
         if (memReqValid)
         begin
            addr_ff <= memReqLine ? {memReqAddr[31:5], 5'h00} : memReqAddr;
            left_ff <= memReqLine ? 4'h8 : 4'h1;
         end
         else if (left_ff != 4'h0 && tick_ff[0])
         begin
            rdValid_ff <= 1'b1;
            rdData_ff <= {addr_ff[15:0], ~addr_ff[15:0]};
            addr_ff <= addr_ff + 32'h4;
            left_ff <= left_ff - 4'h1;
         end
      end
   end
endmodule
